// ===== packetizer_pkg.sv
// Constants, register map and types of the serial data packetizer.
// Assumes a 20 MHz system clock and a 16-bit register port.
package packetizer_pkg;
   localparam int          BUF_DEPTH     = 1024;
   localparam int          BUF_ADDR_W    = 10;
   localparam int          CNT_W         = 11;
   localparam logic [10:0] BUF_FULL_CNT  = 11'h400;

   localparam logic [3:0]  OFS_PKT_LEN   = 4'h0;
   localparam logic [3:0]  OFS_DELIM1    = 4'h1;
   localparam logic [3:0]  OFS_DELIM2    = 4'h2;
   localparam logic [3:0]  OFS_FORCE_MS  = 4'h3;
   localparam logic [3:0]  OFS_STATUS    = 4'h4;

   localparam int          STAT_BUSY_BIT = 15;

   localparam logic [10:0] PKT_LEN_RST   = 11'h000;
   localparam logic [7:0]  DELIM_RST     = 8'h00;
   localparam logic [15:0] FORCE_MS_RST  = 16'h0000;

   localparam int          TICK_MS       = 1;
   localparam int          CLK_PERIOD_NS = 50;
   localparam int          NS_PER_MS     = 1000000;
   localparam int          TICK_CYCLES   =
      (TICK_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic [10:0] pkt_len;
      logic [7:0]  delim1;
      logic [7:0]  delim2;
      logic [15:0] force_ms;
   } cfg_type;

   typedef enum logic [1:0] {ST_FILL, ST_READ, ST_SHOW} state_type;
endpackage

// ===== frame_buffer_mem.sv
// Byte buffer of the packetizer: one write port, one registered read port.
// Assumes the caller never reads and writes the same entry in one cycle.
module frame_buffer_mem #(
   parameter int WIDTH  = 8,
   parameter int DEPTH  = 1024,
   parameter int ADDR_W = 10
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]  wr_data,
   input  wire logic              rd_en,
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic      [WIDTH-1:0]  rd_data
);
   logic [WIDTH-1:0] mem_array [DEPTH];

   // No reset on the array keeps it a plain RAM
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_array[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem_array[rd_addr];
      end
   end
endmodule // frame_buffer_mem

// ===== serial_data_packetizer.sv
// Serial data packetizer: buffers serial bytes, releases them as frames.
// Assumes one clock; the frame sink may stall through frm_ready.
//
// Operation
// - A packet length of zero sets no length limit on a frame.
// - A packet length of 1 to 1024 releases the frame when the count hits it.
// - The first delimiter is an 8-bit value compared with each serial byte.
// - With no delimiter set, every byte is released at once as its own frame.
// - With a delimiter set, bytes are held until the delimiter arrives.
// - A nonzero second delimiter must directly follow the first one.
// - Both delimiters zero switch delimiter matching off.
// - A full 1K buffer is released whole and then emptied.
// - An idle gap longer than the force time after a byte releases the frame.
// - Force time zero disables the idle release; else it counts in ms.
//
// Decided for this implementation: the register offsets and the plain strobed port.
module serial_data_packetizer
   import packetizer_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        ser_valid,
   input  wire logic [7:0]  ser_data,
   output logic             ser_ready,
   output logic             frm_valid,
   output logic      [7:0]  frm_data,
   output logic             frm_last,
   input  wire logic        frm_ready
);
   cfg_type               cfg_reg,    cfg_next;
   logic [15:0]           rdata_reg,  rdata_next;
   state_type             state_reg,  state_next;
   logic [CNT_W-1:0]      cnt_reg,    cnt_next;
   logic [BUF_ADDR_W-1:0] rd_ptr_reg, rd_ptr_next;
   logic [7:0]            prev_reg,   prev_next;
   logic                  prev_ok_reg, prev_ok_next;
   logic [31:0]           div_reg,    div_next;
   logic [15:0]           ms_reg,     ms_next;

   logic                  wr;
   logic                  rd_en;
   logic [CNT_W-1:0]      cnt_inc;
   logic                  no_delim;
   logic                  delim_hit;
   logic                  len_hit;
   logic                  full_hit;
   logic                  idle_hit;
   logic                  last_byte;

   frame_buffer_mem #(
      .WIDTH  (8),
      .DEPTH  (BUF_DEPTH),
      .ADDR_W (BUF_ADDR_W)
   ) frame_buffer_mem_inst (
      .clk     (clk),
      .rst_b   (rst_b),
      .wr_en   (wr),
      .wr_addr (cnt_reg[BUF_ADDR_W-1:0]),
      .wr_data (ser_data),
      .rd_en   (rd_en),
      .rd_addr (rd_ptr_reg),
      .rd_data (frm_data)
   );

   // Register port; config changes act at once, even mid-frame
   always_comb begin
      cfg_next   = cfg_reg;
      rdata_next = 16'h0000;
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_PKT_LEN:  cfg_next.pkt_len  = reg_wdata[10:0];
            OFS_DELIM1:   cfg_next.delim1   = reg_wdata[7:0];
            OFS_DELIM2:   cfg_next.delim2   = reg_wdata[7:0];
            OFS_FORCE_MS: cfg_next.force_ms = reg_wdata;
            default:      cfg_next = cfg_reg;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_PKT_LEN:  rdata_next = {5'h00, cfg_reg.pkt_len};
            OFS_DELIM1:   rdata_next = {8'h00, cfg_reg.delim1};
            OFS_DELIM2:   rdata_next = {8'h00, cfg_reg.delim2};
            OFS_FORCE_MS: rdata_next = cfg_reg.force_ms;
            OFS_STATUS: begin
               rdata_next = {5'h00, cnt_reg};
               rdata_next[STAT_BUSY_BIT] = (state_reg != ST_FILL);
            end
            default:      rdata_next = 16'h0000;
         endcase
      end
   end

   assign reg_rdata = rdata_reg;

   // Release decisions
   always_comb begin
      wr        = ser_valid && (state_reg == ST_FILL);
      cnt_inc   = cnt_reg + 11'h001;
      no_delim  = (cfg_reg.delim1 == 8'h00) && (cfg_reg.delim2 == 8'h00);
      if (no_delim) begin
         delim_hit = 1'b0;
      end else if (cfg_reg.delim2 == 8'h00) begin
         delim_hit = (ser_data == cfg_reg.delim1);
      end else begin
         delim_hit = prev_ok_reg && (prev_reg == cfg_reg.delim1)
                     && (ser_data == cfg_reg.delim2);
      end
      len_hit   = (cfg_reg.pkt_len != 11'h000)
                  && (cnt_inc == cfg_reg.pkt_len);
      full_hit  = (cnt_inc == BUF_FULL_CNT);
      idle_hit  = (state_reg == ST_FILL) && !wr && (cnt_reg != 11'h000)
                  && (cfg_reg.force_ms != 16'h0000)
                  && (ms_reg >= cfg_reg.force_ms);
      last_byte = ({1'b0, rd_ptr_reg} + 11'h001) == cnt_reg;
   end

   assign ser_ready = (state_reg == ST_FILL);
   assign frm_valid = (state_reg == ST_SHOW);
   assign frm_last  = (state_reg == ST_SHOW) && last_byte;
   assign rd_en     = (state_reg == ST_READ);

   // Framing state; drain costs two cycles a byte but needs no extra buffer
   always_comb begin
      state_next   = state_reg;
      cnt_next     = cnt_reg;
      rd_ptr_next  = rd_ptr_reg;
      prev_next    = prev_reg;
      prev_ok_next = prev_ok_reg;
      div_next     = div_reg;
      ms_next      = ms_reg;
      unique case (state_reg)
         ST_FILL: begin
            if (wr) begin
               cnt_next     = cnt_inc;
               prev_next    = ser_data;
               prev_ok_next = 1'b1;
               div_next     = 32'h0000_0000;
               ms_next      = 16'h0000;
               if (no_delim || delim_hit || len_hit || full_hit) begin
                  state_next  = ST_READ;
                  rd_ptr_next = '0;
               end
            end else if (idle_hit) begin
               state_next  = ST_READ;
               rd_ptr_next = '0;
            end else if (cnt_reg != 11'h000) begin
               if (div_reg == 32'(TICK_CYCLES_P - 1)) begin
                  div_next = 32'h0000_0000;
                  if (ms_reg != 16'hffff) begin
                     ms_next = ms_reg + 16'h0001;
                  end
               end else begin
                  div_next = div_reg + 32'h0000_0001;
               end
            end
         end
         ST_READ: begin
            state_next = ST_SHOW;
         end
         ST_SHOW: begin
            if (frm_ready) begin
               if (last_byte) begin
                  state_next   = ST_FILL;
                  cnt_next     = '0;
                  prev_ok_next = 1'b0;
                  div_next     = 32'h0000_0000;
                  ms_next      = 16'h0000;
               end else begin
                  rd_ptr_next = rd_ptr_reg + 10'h001;
                  state_next  = ST_READ;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_reg     <= '{PKT_LEN_RST, DELIM_RST, DELIM_RST, FORCE_MS_RST};
         rdata_reg   <= 16'h0000;
         state_reg   <= ST_FILL;
         cnt_reg     <= '0;
         rd_ptr_reg  <= '0;
         prev_reg    <= 8'h00;
         prev_ok_reg <= 1'b0;
         div_reg     <= 32'h0000_0000;
         ms_reg      <= 16'h0000;
      end else begin
         cfg_reg     <= cfg_next;
         rdata_reg   <= rdata_next;
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         rd_ptr_reg  <= rd_ptr_next;
         prev_reg    <= prev_next;
         prev_ok_reg <= prev_ok_next;
         div_reg     <= div_next;
         ms_reg      <= ms_next;
      end
   end
endmodule // serial_data_packetizer

// ===== serial_source_model.sv
// Serial source model: sends queued bytes under valid/ready.
// Assumes the bench pushes bytes into fifo_q.
module serial_source_model (
   input  wire logic       clk,
   input  wire logic       ser_ready,
   output logic            ser_valid,
   output logic      [7:0] ser_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] fifo_q[$];
   initial ser_valid = 1'b0;
   initial ser_data = 8'h00;
   // Idle data flips so a stale byte never passes as fresh
   always @(posedge clk) begin
      if (ser_valid && ser_ready) void'(fifo_q.pop_front());
      ser_valid <= fifo_q.size() != 0;
      ser_data <= (fifo_q.size() != 0) ? fifo_q[0] : ~ser_data;
   end
endmodule // serial_source_model

// ===== sdp_assertions.sv
// Port checker of the serial data packetizer.
// Assumes config changes only through the register port.
module sdp_checker
   import packetizer_pkg::*;
#(parameter int TICK_CYCLES_P = 4) (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        ser_valid,
   input wire logic [7:0]  ser_data,
   input wire logic        ser_ready,
   input wire logic        frm_valid,
   input wire logic [7:0]  frm_data,
   input wire logic        frm_last,
   input wire logic        frm_ready
);
   logic [10:0] len_reg, cnt_reg;
   logic [7:0]  d1_reg, d2_reg, prev_reg;
   logic [15:0] force_reg;
   // Cycles since the last byte while accepting
   logic [31:0] idle_reg;
   logic        take;
   assign take = ser_valid && ser_ready;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {len_reg, cnt_reg, d1_reg, d2_reg, prev_reg} <= '0;
         force_reg <= 16'h0000;
         idle_reg  <= 32'h0000_0000;
      end else begin
         if (reg_wr && reg_addr == OFS_FORCE_MS) force_reg <= reg_wdata;
         idle_reg <= (take || !ser_ready) ? 32'h0000_0000
                                          : idle_reg + 32'h0000_0001;
         if (take) cnt_reg <= cnt_reg + 11'h001;
         if (frm_valid && frm_ready && frm_last) cnt_reg <= 11'h000;
         if (take) prev_reg <= ser_data;
         if (reg_wr && reg_addr == OFS_PKT_LEN) len_reg <= reg_wdata[10:0];
         if (reg_wr && reg_addr == OFS_DELIM1) d1_reg <= reg_wdata[7:0];
         if (reg_wr && reg_addr == OFS_DELIM2) d2_reg <= reg_wdata[7:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_DRAIN_HOLD: assert property (
      frm_valid && !frm_ready |=> frm_valid && $stable(frm_data))
      else $error("stalled byte changed");
   AST_NO_TAKE: assert property (
      frm_valid |-> !ser_ready) else $error("byte taken in drain");
   AST_ECHO: assert property (
      take && d1_reg == 8'h00 && d2_reg == 8'h00 |=> !ser_ready ##1
      frm_valid && frm_last && frm_data == $past(ser_data, 2))
      else $error("byte not sent alone");
   AST_DELIM: assert property (
      take && d2_reg == 8'h00 && d1_reg != 8'h00 && ser_data == d1_reg
      |=> !ser_ready ##1 frm_valid) else $error("delimiter ignored");
   AST_PAIR: assert property (
      take && d2_reg != 8'h00 && cnt_reg != 11'h000 && prev_reg == d1_reg
      && ser_data == d2_reg |=> !ser_ready) else $error("pair ignored");
   AST_LEN: assert property (
      take && len_reg != 11'h000 && cnt_reg + 11'h001 == len_reg
      |=> !ser_ready) else $error("length ignored");
   AST_FULL: assert property (
      take && cnt_reg == 11'h3ff |=> !ser_ready ##1 frm_valid)
      else $error("full buffer kept");
   AST_HOLD: assert property (
      take && len_reg == 11'h000 && d1_reg != 8'h00 && d2_reg == 8'h00
      && ser_data != d1_reg && cnt_reg != 11'h3ff |=> ser_ready)
      else $error("early release");
   AST_IDLE: assert property (
      ser_ready && !take && cnt_reg != 11'h000 && force_reg != 16'h0000
      && idle_reg == force_reg * TICK_CYCLES_P |=> !ser_ready)
      else $error("idle release missed");
   AST_NO_IDLE: assert property (
      ser_ready && !take && force_reg == 16'h0000 |=> ser_ready)
      else $error("release with timeout off");
endmodule // sdp_checker

bind serial_data_packetizer sdp_checker #(.TICK_CYCLES_P(TICK_CYCLES_P))
   sdp_checker_inst (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
   .ser_valid, .ser_data, .ser_ready, .frm_valid, .frm_data, .frm_last,
   .frm_ready);

// ===== serial_data_packetizer_test.sv
// Bench of the serial data packetizer with a serial source model.
// Assumes package, design, checker and source model compiled first.
module serial_data_packetizer_test;
   import packetizer_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        ser_valid, ser_ready, frm_valid, frm_last, frm_ready = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic [7:0]  ser_data, frm_data, exp_q[$], rx_q[$];
   int          len_q[$], errors = 0, check_count = 0, rx_n = 0;
   always #25 clk = ~clk;
   serial_data_packetizer #(.TICK_CYCLES_P(4)) serial_data_packetizer_inst (
      .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .ser_valid, .ser_data, .ser_ready, .frm_valid, .frm_data, .frm_last,
      .frm_ready);
   serial_source_model serial_source_model_inst (.clk, .ser_ready,
      .ser_valid, .ser_data);
   // Sink stalls every other cycle
   always @(posedge clk) begin
      if (frm_valid && frm_ready) begin
         rx_q.push_back(frm_data);
         rx_n++;
         if (frm_last) begin
            len_q.push_back(rx_n);
            rx_n = 0;
         end
      end
      frm_ready <= ~frm_ready;
   end
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(string name, logic [15:0] e, logic [15:0] got);
      check_count++;
      if (got !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, e, got);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", e, reg_rdata);
   endtask
   task automatic cfg(logic [10:0] n, logic [7:0] a, b, logic [15:0] f);
      wr(OFS_PKT_LEN, {5'h00, n});
      wr(OFS_DELIM1, {8'h00, a});
      wr(OFS_DELIM2, {8'h00, b});
      wr(OFS_FORCE_MS, f);
   endtask
   task automatic send(logic [7:0] b);
      serial_source_model_inst.fifo_q.push_back(b);
      exp_q.push_back(b);
   endtask
   task automatic frame(int n);
      int i;
      for (i = 0; i < 9000 && len_q.size() == 0; i++) @(posedge clk);
      if (len_q.size() == 0) begin
         errors++;
         $display("ERROR frame expected %0d seen none", n);
         tally_and_finish();
      end else begin
         chk("frame_len", 16'(n), 16'(len_q.pop_front()));
         for (i = 0; i < n; i++)
            chk("frame_byte", {8'h00, exp_q.pop_front()},
               {8'h00, rx_q.pop_front()});
      end
   endtask
   task automatic test_regs();
      rd(OFS_PKT_LEN, 16'h0000);
      rd(OFS_DELIM1, 16'h0000);
      rd(OFS_DELIM2, 16'h0000);
      rd(OFS_FORCE_MS, 16'h0000);
      rd(4'h7, 16'h0000);
      wr(OFS_FORCE_MS, 16'hffff);
      rd(OFS_FORCE_MS, 16'hffff);
      wr(OFS_FORCE_MS, 16'h0000);
   endtask
   task automatic test_echo();
      send(8'h5a);
      send(8'ha5);
      frame(1);
      frame(1);
   endtask
   task automatic test_delim();
      cfg(11'h000, 8'h0d, 8'h00, 16'h0000);
      send(8'h11);
      send(8'h22);
      repeat (40) @(posedge clk);
      chk("early_frames", 16'h0000, 16'(len_q.size()));
      send(8'h0d);
      frame(3);
   endtask
   task automatic test_pair();
      cfg(11'h000, 8'h0d, 8'h0a, 16'h0000);
      send(8'h0d);
      send(8'h33);
      send(8'h0d);
      send(8'h0a);
      frame(4);
   endtask
   task automatic test_len_idle();
      cfg(11'h003, 8'hee, 8'h00, 16'h0002);
      for (int i = 1; i < 6; i++) send(8'(i));
      frame(3);
      frame(2);
   endtask
   task automatic test_full();
      cfg(11'h000, 8'hee, 8'h00, 16'h0000);
      for (int i = 0; i < 1024; i++) send(8'(i) & 8'h7f);
      frame(1024);
      send(8'h01);
      send(8'hee);
      frame(2);
   endtask
   // Mid-run reset drops the held byte and restores defaults
   task automatic test_reset();
      cfg(11'h000, 8'h0d, 8'h00, 16'h0000);
      send(8'h44);
      repeat (4) @(posedge clk);
      rd(OFS_STATUS, 16'h0001);
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      #1 chk("ser_ready", 16'h0001, {15'h0000, ser_ready});
      chk("frm_valid", 16'h0000, {15'h0000, frm_valid});
      chk("frm_last", 16'h0000, {15'h0000, frm_last});
      chk("frm_data", 16'h0000, {8'h00, frm_data});
      @(posedge clk);
      rst_b <= 1'b1;
      void'(exp_q.pop_front());
      rd(OFS_STATUS, 16'h0000);
      rd(OFS_DELIM1, 16'h0000);
      send(8'h66);
      frame(1);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      test_regs();
      test_echo();
      test_delim();
      test_pair();
      test_len_idle();
      test_full();
      test_reset();
      chk("spare_frames", 16'h0000, 16'(len_q.size()));
      tally_and_finish();
   end
endmodule // serial_data_packetizer_test
